// ===== verilog/seq_pkg.sv
// constants and types for the warm-up and measurement sequencer
package seq_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ;
  localparam int unsigned TEMP_W = 10;
  localparam logic [9:0] TEMP_TARGET = 10'h145;
  localparam logic [9:0] TEMP_OZONE = 10'h0fa;
  localparam logic [4:0] BG_FILL_S = 5'h08;
  localparam logic [4:0] BG_MEAS_S = 5'h03;
  localparam logic [4:0] FILL_S = 5'h03;
  localparam logic [4:0] FILL_HI_S = 5'h09;
  localparam logic [4:0] FLUSH_EXTRA_S = 5'h04;
  localparam logic [4:0] MEAS_S = 5'h03;
  localparam logic [2:0] PAIRS_STD = 3'h5;
  localparam logic [2:0] PAIRS_TRACE = 3'h3;
  localparam logic [7:0] CONTRAST_RESET = 8'h80;
  localparam logic [7:0] CONTRAST_MAX = 8'hff;
  localparam logic [7:0] CONTRAST_MIN = 8'h00;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_POINT = 8'h2e;
  localparam logic [7:0] CH_UNDER = 8'h5f;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_UPPER_A = 8'h41;
  localparam logic [7:0] CH_LOWER_A = 8'h61;
  typedef enum logic [3:0] {
    S_HV_CHECK = 4'h0,
    S_HV_ADJUST = 4'h1,
    S_HEAT = 4'h3,
    S_BG_FILL = 4'h2,
    S_BG_MEAS = 4'h6,
    S_NO_FILL = 4'h7,
    S_NO_MEAS = 4'h5,
    S_NOX_FILL = 4'h4,
    S_NOX_MEAS = 4'hc
  } seq_state_t;
  typedef enum logic [1:0] {
    A_NONE = 2'h0,
    A_CHAR = 2'h1,
    A_STEP = 2'h2
  } key_action_t;
endpackage : seq_pkg

// ===== verilog/analyser_seq.sv
// sequencer: warm-up, fill/measure cycle, status lights and keypad editing
// Notes on behaviour
// [R01] no measurement output while warm-up runs after power-on
// [R02] warm-up adjusts detector high-voltage pot only when tuning flag is set
// [R03] heater setpoint rises stepwise until converter reaches 325 degrees
// [R04] at 250 degrees ozone turns on, measuring starts, warm-up ends
// [R05] after background, five NO/NOx pairs before next background
// [R06] trace-range units run three pairs between backgrounds
// [R07] background fill lasts 8 s, background measure 3 s
// [R08] NO fill lasts 3 s, or 9 s on high range
// [R09] first sample fill after background gets 4 extra seconds
// [R10] NO measure lasts 3 s after NO fill
// [R11] NOx fill 3 s or 9 s high range, then NOx measure 3 s
// [R12] NO2 result is NOx result minus NO result
// [R13] red on major failure, orange on minor fault, green when fault free
// [R14] green button closes any edit or menu and returns home
// [R15] in bootloader all status lights off, keypad backlight on
// [R16] repeated number key cycles digit, upper letters, lower letters
// [R17] float edit: decimal key gives minus at start if allowed, else point
// [R18] float edit: plus key gives plus at start, else space
// [R19] other fields: plus/decimal step value by one, month in date month
// [R20] home screen: held up/down raises/lowers contrast continuously
// [R21] state durations come from a reloading one-second tick counter
module analyser_seq
  import seq_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned CONTRAST_DIV = 1_000_000
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic TUNE_REQ,
  output logic HV_ADJUST,
  input wire logic HV_DONE,
  input wire logic [9:0] CONV_TEMP,
  output logic [9:0] HEAT_SETPOINT,
  output logic OZONE_ON,
  output logic WARMUP,
  input wire logic HIGH_RANGE,
  input wire logic TRACE_RANGE,
  output logic [3:0] SEQ_STATE,
  output logic MEAS_VALID,
  input wire logic [15:0] SIGNAL_IN,
  output logic [15:0] NO_RESULT,
  output logic [15:0] NOX_RESULT,
  output logic [15:0] NO2_RESULT,
  input wire logic FAULT_MAJOR,
  input wire logic FAULT_MINOR,
  input wire logic BOOTLOADER,
  output logic LED_RED,
  output logic LED_ORANGE,
  output logic LED_GREEN,
  output logic BACKLIGHT,
  input wire logic BTN_GREEN,
  input wire logic HOME_SCREEN,
  output logic GO_HOME,
  input wire logic KEY_PRESS,
  input wire logic [3:0] KEY_DIGIT,
  input wire logic KEY_PLUS,
  input wire logic KEY_POINT,
  input wire logic EDIT_TEXT,
  input wire logic EDIT_FLOAT,
  input wire logic EDIT_MONTH,
  input wire logic CURSOR_AT_START,
  input wire logic NEG_ALLOWED,
  output logic [7:0] EDIT_CHAR,
  output logic CHAR_VALID,
  output logic STEP_UP,
  output logic STEP_DOWN,
  output logic MONTH_STEP,
  input wire logic KEY_UP_HELD,
  input wire logic KEY_DOWN_HELD,
  output logic [7:0] CONTRAST
);
  if (TICK_DIV < 2 || CONTRAST_DIV < 2) begin : g_bad_div
    $error("dividers must be at least 2");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] s1, s2;
  always_ff @(posedge CLK) begin
    s1 <= {BTN_GREEN, KEY_UP_HELD, KEY_DOWN_HELD};
    s2 <= s1;
  end
  logic btn_green_q;
  always_ff @(posedge CLK) begin
    if (SRST) btn_green_q <= 1'b0;
    else btn_green_q <= s2[2];
  end

  // ****************************************
  // one-second tick
  // ****************************************
  logic [31:0] tick_cnt;
  logic tick;
  assign tick = (tick_cnt == 32'(TICK_DIV - 1));
  always_ff @(posedge CLK) begin
    if (SRST || tick) tick_cnt <= '0;
    else tick_cnt <= tick_cnt + 32'h1;
  end

  // ****************************************
  // sequencer
  // ****************************************
  seq_state_t state, next_state;
  logic [4:0] secs, next_secs;
  logic [2:0] pairs;
  logic [4:0] fill_len;
  assign fill_len = HIGH_RANGE ? FILL_HI_S : FILL_S; // [R08] [R11]

  function automatic logic [4:0] fill_time(input logic first, input logic [4:0] base);
    fill_time = first ? 5'(base + FLUSH_EXTRA_S) : base; // [R09]
  endfunction : fill_time

  logic expire;
  assign expire = tick && secs == 5'h01; // [R21]

  always_comb begin
    next_state = state;
    next_secs = secs;
    case (state)
      S_HV_CHECK: next_state = TUNE_REQ ? S_HV_ADJUST : S_HEAT; // [R02]
      S_HV_ADJUST: if (HV_DONE) next_state = S_HEAT;
      S_HEAT: if (CONV_TEMP >= TEMP_OZONE) begin
        next_state = S_BG_FILL; // [R04]
        next_secs = BG_FILL_S; // [R07]
      end
      S_BG_FILL: if (expire) begin
        next_state = S_BG_MEAS;
        next_secs = BG_MEAS_S; // [R07]
      end
      S_BG_MEAS: if (expire) begin
        next_state = S_NO_FILL;
        next_secs = fill_time(1'b1, fill_len); // [R09]
      end
      S_NO_FILL: if (expire) begin
        next_state = S_NO_MEAS;
        next_secs = MEAS_S; // [R10]
      end
      S_NO_MEAS: if (expire) begin
        next_state = S_NOX_FILL;
        next_secs = fill_len; // [R11]
      end
      S_NOX_FILL: if (expire) begin
        next_state = S_NOX_MEAS;
        next_secs = MEAS_S; // [R11]
      end
      S_NOX_MEAS: if (expire) begin
        // at or above, so a range change mid-cycle cannot skip the limit
        if (pairs >= (TRACE_RANGE ? PAIRS_TRACE : PAIRS_STD)) begin // [R05] [R06]
          next_state = S_BG_FILL;
          next_secs = BG_FILL_S;
        end else begin
          next_state = S_NO_FILL;
          next_secs = fill_len;
        end
      end
      default: next_state = S_HV_CHECK;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state <= S_HV_CHECK;
      secs <= '0;
    end else begin
      state <= next_state;
      if (next_state != state) secs <= next_secs; // [R21]
      else if (tick && secs != 5'h00) secs <= secs - 5'h01; // [R21]
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      pairs <= '0;
    end else if (state == S_BG_MEAS) begin
      pairs <= 3'h1;
    end else if (state == S_NOX_MEAS && next_state == S_NO_FILL) begin
      pairs <= pairs + 3'h1; // [R05]
    end
  end

  logic warm;
  assign warm = state == S_HV_CHECK || state == S_HV_ADJUST || state == S_HEAT;
  assign WARMUP = warm; // [R01]
  assign HV_ADJUST = state == S_HV_ADJUST; // [R02]
  assign SEQ_STATE = state;

  always_ff @(posedge CLK) begin
    if (SRST) OZONE_ON <= 1'b0;
    else if (state == S_HEAT && CONV_TEMP >= TEMP_OZONE) OZONE_ON <= 1'b1; // [R04]
  end

  // heater ramps one degree per second while converter is no more than 16 degrees below setpoint; slow ramp spares the element
  always_ff @(posedge CLK) begin
    if (SRST) HEAT_SETPOINT <= '0;
    else if (tick && HEAT_SETPOINT < TEMP_TARGET && {1'b0, CONV_TEMP} + 11'h010 >= {1'b0, HEAT_SETPOINT})
      HEAT_SETPOINT <= HEAT_SETPOINT + 10'h001; // [R03]
  end

  // ****************************************
  // results
  // ****************************************
  always_ff @(posedge CLK) begin
    if (SRST) begin
      NO_RESULT <= '0;
      NOX_RESULT <= '0;
      NO2_RESULT <= '0;
      MEAS_VALID <= 1'b0;
    end else begin
      MEAS_VALID <= 1'b0;
      if (!warm && expire && state == S_NO_MEAS) NO_RESULT <= SIGNAL_IN; // [R01]
      if (!warm && expire && state == S_NOX_MEAS) begin
        NOX_RESULT <= SIGNAL_IN;
        NO2_RESULT <= SIGNAL_IN - NO_RESULT; // [R12]
        MEAS_VALID <= 1'b1; // [R01]
      end
    end
  end

  // ****************************************
  // lights and home button
  // ****************************************
  always_ff @(posedge CLK) begin
    if (SRST) begin
      LED_RED <= 1'b0;
      LED_ORANGE <= 1'b0;
      LED_GREEN <= 1'b0;
      BACKLIGHT <= 1'b0;
    end else begin
      LED_RED <= !BOOTLOADER && FAULT_MAJOR; // [R13] [R15]
      LED_ORANGE <= !BOOTLOADER && !FAULT_MAJOR && FAULT_MINOR; // [R13]
      LED_GREEN <= !BOOTLOADER && !FAULT_MAJOR && !FAULT_MINOR; // [R13]
      BACKLIGHT <= BOOTLOADER; // [R15]
    end
  end
  assign GO_HOME = s2[2] && !btn_green_q; // [R14]

  // ****************************************
  // keypad editing
  // ****************************************
  logic [3:0] last_key;
  logic [3:0] press_idx;
  function automatic logic [3:0] key_len(input logic [3:0] k);
    case (k)
      4'h0, 4'h1: key_len = 4'h3;
      4'h7, 4'h9: key_len = 4'h9;
      default: key_len = 4'h7;
    endcase
  endfunction : key_len
  function automatic logic [7:0] key_char(input logic [3:0] k, input logic [3:0] i);
    logic [7:0] base;
    logic [3:0] n;
    base = 8'h00;
    n = 4'h0;
    if (k == 4'h2) base = 8'h00;
    else if (k <= 4'h7) base = 8'((k - 4'h2) * 3);
    else if (k == 4'h8) base = 8'h13;
    else base = 8'h16;
    n = (key_len(k) - 4'h1) >> 1;
    if (i == 4'h0) key_char = CH_ZERO + 8'(k);
    else if (k <= 4'h1) key_char = (i == 4'h1) ? CH_SPACE : CH_UNDER;
    else if (i <= n) key_char = CH_UPPER_A + base + 8'(i - 4'h1);
    else key_char = CH_LOWER_A + base + 8'(i - n - 4'h1);
  endfunction : key_char

  always_ff @(posedge CLK) begin
    if (SRST) begin
      last_key <= 4'hf;
      press_idx <= '0;
      EDIT_CHAR <= '0;
      CHAR_VALID <= 1'b0;
      STEP_UP <= 1'b0;
      STEP_DOWN <= 1'b0;
      MONTH_STEP <= 1'b0;
    end else begin
      CHAR_VALID <= 1'b0;
      STEP_UP <= 1'b0;
      STEP_DOWN <= 1'b0;
      MONTH_STEP <= 1'b0;
      if (KEY_PRESS && KEY_PLUS) begin
        last_key <= 4'hf;
        if (EDIT_FLOAT) begin
          EDIT_CHAR <= CURSOR_AT_START ? CH_PLUS : CH_SPACE; // [R18]
          CHAR_VALID <= 1'b1;
        end else begin
          STEP_UP <= 1'b1; // [R19]
          MONTH_STEP <= EDIT_MONTH; // [R19]
        end
      end else if (KEY_PRESS && KEY_POINT) begin
        last_key <= 4'hf;
        if (EDIT_FLOAT) begin
          EDIT_CHAR <= (CURSOR_AT_START && NEG_ALLOWED) ? CH_MINUS : CH_POINT; // [R17]
          CHAR_VALID <= 1'b1;
        end else begin
          STEP_DOWN <= 1'b1; // [R19]
          MONTH_STEP <= EDIT_MONTH; // [R19]
        end
      end else if (KEY_PRESS && KEY_DIGIT <= 4'h9) begin
        if (EDIT_TEXT && KEY_DIGIT == last_key) begin
          press_idx <= (press_idx + 4'h1 == key_len(KEY_DIGIT)) ? 4'h0 : press_idx + 4'h1; // [R16]
          EDIT_CHAR <= key_char(KEY_DIGIT,
            (press_idx + 4'h1 == key_len(KEY_DIGIT)) ? 4'h0 : press_idx + 4'h1); // [R16]
        end else begin
          press_idx <= 4'h0;
          EDIT_CHAR <= CH_ZERO + 8'(KEY_DIGIT);
        end
        last_key <= KEY_DIGIT;
        CHAR_VALID <= 1'b1;
      end
    end
  end

  // ****************************************
  // contrast; rate divider keeps a hold from racing to the limit
  // ****************************************
  logic [31:0] ctr_cnt;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctr_cnt <= '0;
      CONTRAST <= CONTRAST_RESET;
    end else if (!HOME_SCREEN || !(s2[1] ^ s2[0])) begin
      ctr_cnt <= '0;
    end else if (ctr_cnt == 32'(CONTRAST_DIV - 1)) begin
      ctr_cnt <= '0;
      if (s2[1] && CONTRAST != CONTRAST_MAX) CONTRAST <= CONTRAST + 8'h01; // [R20]
      if (s2[0] && CONTRAST != CONTRAST_MIN) CONTRAST <= CONTRAST - 8'h01; // [R20]
    end else begin
      ctr_cnt <= ctr_cnt + 32'h1;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_no_meas_warm;
    @(posedge CLK) disable iff (SRST) WARMUP |-> !MEAS_VALID;
  endproperty
  a_no_meas_warm: assert property (p_no_meas_warm) else $error("result during warm-up"); // [R01]
  property p_hv_only_req;
    @(posedge CLK) disable iff (SRST) (state == S_HV_CHECK && !TUNE_REQ) |=> !HV_ADJUST;
  endproperty
  a_hv_only_req: assert property (p_hv_only_req) else $error("hv adjust without request"); // [R02]
  property p_ozone;
    @(posedge CLK) disable iff (SRST) (state == S_HEAT && CONV_TEMP >= TEMP_OZONE) |=> OZONE_ON && !WARMUP;
  endproperty
  a_ozone: assert property (p_ozone) else $error("ozone not started"); // [R04]
  property p_setpoint;
    @(posedge CLK) disable iff (SRST) HEAT_SETPOINT <= TEMP_TARGET;
  endproperty
  a_setpoint: assert property (p_setpoint) else $error("setpoint overshoot"); // [R03]
  property p_bg_meas_len;
    @(posedge CLK) disable iff (SRST) (state == S_BG_FILL && next_state == S_BG_MEAS) |=> secs == BG_MEAS_S;
  endproperty
  a_bg_meas_len: assert property (p_bg_meas_len) else $error("bad background time"); // [R07]
  property p_first_fill;
    @(posedge CLK) disable iff (SRST)
      (state == S_BG_MEAS && expire) |=> secs == 5'(fill_len + FLUSH_EXTRA_S);
  endproperty
  a_first_fill: assert property (p_first_fill) else $error("flush extension missing"); // [R09]
  property p_no2;
    @(posedge CLK) disable iff (SRST) MEAS_VALID |-> NO2_RESULT == NOX_RESULT - NO_RESULT;
  endproperty
  a_no2: assert property (p_no2) else $error("no2 mismatch"); // [R12]
  property p_lights;
    @(posedge CLK) disable iff (SRST) $past(BOOTLOADER) |-> !LED_RED && !LED_ORANGE && !LED_GREEN && BACKLIGHT;
  endproperty
  a_lights: assert property (p_lights) else $error("bootloader lights wrong"); // [R15]
  property p_pairs;
    @(posedge CLK) disable iff (SRST) pairs <= PAIRS_STD;
  endproperty
  a_pairs: assert property (p_pairs) else $error("pair count overrun"); // [R05]
  c_bg: cover property (@(posedge CLK) state == S_NOX_MEAS && next_state == S_BG_FILL);
  c_hv: cover property (@(posedge CLK) HV_ADJUST);
  c_result: cover property (@(posedge CLK) MEAS_VALID);
endmodule : analyser_seq

// ===== bench/analyser_far_side.sv
// far-side model: converter heater and high-voltage tuning supply
module analyser_far_side #(
  parameter int unsigned HV_DELAY = 5
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic HV_ADJUST,
  input wire logic [9:0] HEAT_SETPOINT,
  output logic HV_DONE,
  output logic [9:0] CONV_TEMP
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned hv_wait;
  // ************************
  // converter temperature
  // ************************
  // one degree a cycle; the real lag is minutes, far too slow to simulate
  always_ff @(posedge CLK) begin
    if (SRST) begin
      CONV_TEMP <= 10'h014;
    end else if (CONV_TEMP < HEAT_SETPOINT) begin
      CONV_TEMP <= CONV_TEMP + 10'h001;
    end else if (CONV_TEMP > HEAT_SETPOINT) begin
      CONV_TEMP <= CONV_TEMP - 10'h001;
    end
  end
  // ************************
  // high-voltage tuning
  // ************************
  always_ff @(posedge CLK) begin
    if (SRST || !HV_ADJUST) begin
      hv_wait <= 0;
      HV_DONE <= 1'b0;
    end else begin
      hv_wait <= hv_wait + 1;
      HV_DONE <= (hv_wait >= HV_DELAY);
    end
  end
endmodule : analyser_far_side

// ===== bench/analyser_seq_test.sv
// self-checking bench for the warm-up and measurement sequencer
module analyser_seq_test;
  import seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TDIV = 10;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic tune_req = 1'b0, high_range = 1'b0, trace_range = 1'b0, hv_adjust, hv_done, ozone_on, warmup;
  logic fault_major = 1'b0, fault_minor = 1'b0, bootloader = 1'b0, btn_green = 1'b0, home_screen = 1'b0;
  logic key_press = 1'b0, key_plus = 1'b0, key_point = 1'b0, edit_text = 1'b0, edit_float = 1'b0;
  logic edit_month = 1'b0, cursor_at_start = 1'b0, neg_allowed = 1'b0, key_up_held = 1'b0, key_down_held = 1'b0;
  logic [3:0] key_digit = 4'h0;
  logic [15:0] signal_in = 16'h0000;
  logic [9:0] conv_temp, heat_setpoint;
  logic [3:0] seq_state;
  logic [15:0] no_result, nox_result, no2_result;
  logic meas_valid, led_red, led_orange, led_green, backlight, go_home;
  logic [7:0] edit_char, contrast;
  logic char_valid, step_up, step_down, month_step;
  int fails = 0;
  int samples_checked = 0;
  int valid_count = 0;
  always #5 clk = ~clk;
  analyser_seq #(.TICK_DIV(TDIV), .CONTRAST_DIV(4)) uut (
    .CLK(clk), .SRST(srst), .TUNE_REQ(tune_req), .HV_ADJUST(hv_adjust), .HV_DONE(hv_done),
    .CONV_TEMP(conv_temp), .HEAT_SETPOINT(heat_setpoint), .OZONE_ON(ozone_on), .WARMUP(warmup),
    .HIGH_RANGE(high_range), .TRACE_RANGE(trace_range), .SEQ_STATE(seq_state), .MEAS_VALID(meas_valid),
    .SIGNAL_IN(signal_in), .NO_RESULT(no_result), .NOX_RESULT(nox_result), .NO2_RESULT(no2_result),
    .FAULT_MAJOR(fault_major), .FAULT_MINOR(fault_minor), .BOOTLOADER(bootloader), .LED_RED(led_red),
    .LED_ORANGE(led_orange), .LED_GREEN(led_green), .BACKLIGHT(backlight), .BTN_GREEN(btn_green),
    .HOME_SCREEN(home_screen), .GO_HOME(go_home), .KEY_PRESS(key_press), .KEY_DIGIT(key_digit),
    .KEY_PLUS(key_plus), .KEY_POINT(key_point), .EDIT_TEXT(edit_text), .EDIT_FLOAT(edit_float),
    .EDIT_MONTH(edit_month), .CURSOR_AT_START(cursor_at_start), .NEG_ALLOWED(neg_allowed),
    .EDIT_CHAR(edit_char), .CHAR_VALID(char_valid), .STEP_UP(step_up), .STEP_DOWN(step_down),
    .MONTH_STEP(month_step), .KEY_UP_HELD(key_up_held), .KEY_DOWN_HELD(key_down_held), .CONTRAST(contrast));
  analyser_far_side #(.HV_DELAY(7)) far (.CLK(clk), .SRST(srst), .HV_ADJUST(hv_adjust),
    .HEAT_SETPOINT(heat_setpoint), .HV_DONE(hv_done), .CONV_TEMP(conv_temp));
  // ************************
  // reporting
  // ************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  // ************************
  // sample source and result monitor
  // ************************
  // distinct levels per gas so a result latched in the wrong state shows
  always @(posedge clk) begin
    if (meas_valid === 1'b1) begin
      valid_count++;
      check("no result", 16'h0100, no_result);
      check("nox result", 16'h0340, nox_result);
      check("no2 result", 16'h0240, no2_result);
    end
    #1;
    signal_in = (seq_state == S_NOX_FILL || seq_state == S_NOX_MEAS) ? 16'h0340 :
                (seq_state == S_NO_FILL || seq_state == S_NO_MEAS) ? 16'h0100 : 16'h0011;
  end
  // ************************
  // scenarios
  // ************************
  task automatic do_reset();
    @(posedge clk) #1 srst = 1'b1;
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
  endtask : do_reset
  task automatic warm_up();
    int n;
    logic seen = 1'b0;
    logic early = 1'b0;
    do_reset();
    repeat (30) @(posedge clk) #1 seen |= hv_adjust;
    check("adjust without flag", 16'h0, {15'h0, seen});
    check("heat state", 16'(S_HEAT), {12'h0, seq_state});
    tune_req = 1'b1;
    do_reset();
    seen = 1'b0;
    repeat (20) @(posedge clk) #1 seen |= hv_adjust;
    check("adjust with flag", 16'h1, {15'h0, seen});
    seen = 1'b0;
    for (n = 0; n < 6000 && warmup !== 1'b0; n++) begin
      @(posedge clk) #1;
      seen |= meas_valid;
      early |= ozone_on & (conv_temp < 10'h0f8);
    end
    if (n == 6000) begin
      check("warm-up end", 16'h0, 16'h1);
      end_of_test();
    end
    check("output in warm-up", 16'h0, {15'h0, seen});
    check("ozone early", 16'h0, {15'h0, early});
    check("ozone on", 16'h1, {15'h0, ozone_on});
    check("first state", 16'(S_BG_FILL), {12'h0, seq_state});
  endtask : warm_up
  task automatic phase(input string what, input logic [3:0] st, input int ticks);
    int n;
    check(what, {12'h0, st}, {12'h0, seq_state});
    for (n = 0; n < 400 && seq_state === st; n++) @(posedge clk) #1;
    check(what, 16'h1, {15'h0, n > (ticks - 1) * int'(TDIV) && n <= ticks * int'(TDIV)});
    if (n == 400) end_of_test();
  endtask : phase
  task automatic run_cycle(input logic hi, input logic tr);
    int p;
    int v;
    int f;
    high_range = hi;
    trace_range = tr;
    f = hi ? int'(FILL_HI_S) : int'(FILL_S);
    v = valid_count + int'(meas_valid);
    phase("bg fill", S_BG_FILL, BG_FILL_S);
    phase("bg meas", S_BG_MEAS, BG_MEAS_S);
    for (p = 0; p < (tr ? 3 : 5); p++) begin
      phase("no fill", S_NO_FILL, p == 0 ? f + int'(FLUSH_EXTRA_S) : f);
      phase("no meas", S_NO_MEAS, MEAS_S);
      phase("nox fill", S_NOX_FILL, f);
      phase("nox meas", S_NOX_MEAS, MEAS_S);
    end
    check("pairs", tr ? 16'(PAIRS_TRACE) : 16'(PAIRS_STD), 16'(valid_count + int'(meas_valid) - v));
  endtask : run_cycle
  task automatic lights();
    int i;
    logic [2:0] cfg [4] = '{3'b000, 3'b001, 3'b010, 3'b110};
    logic [2:0] led [4] = '{3'b001, 3'b010, 3'b100, 3'b000};
    for (i = 0; i < 4; i++) begin
      {bootloader, fault_major, fault_minor} = cfg[i];
      repeat (2) @(posedge clk);
      #1 check("lights", 16'(led[i]), {13'h0, led_red, led_orange, led_green});
    end
    check("backlight", 16'h1, {15'h0, backlight});
    {bootloader, fault_major, fault_minor} = 3'b000;
  endtask : lights
  task automatic green_button();
    int hits = 0;
    edit_float = 1'b1;
    btn_green = 1'b1;
    repeat (8) @(posedge clk) #1 hits += int'(go_home === 1'b1);
    btn_green = 1'b0;
    check("go home pulses", 16'h1, 16'(hits));
  endtask : green_button
  task automatic key(input logic [3:0] d, input logic pl, input logic pt);
    @(posedge clk) #1;
    key_digit = d;
    key_plus = pl;
    key_point = pt;
    key_press = 1'b1;
    @(posedge clk) #1;
    key_press = 1'b0;
  endtask : key
  task automatic text_keys(input logic [3:0] d, input string s);
    int i;
    for (i = 0; i < s.len(); i++) begin
      key(d, 1'b0, 1'b0);
      check("text char", {8'h01, s[i]}, {7'h0, char_valid, edit_char});
    end
  endtask : text_keys
  task automatic edit_keys();
    int i;
    logic [2:0] fc [5] = '{3'b110, 3'b100, 3'b010, 3'b101, 3'b001};
    logic [7:0] fe [5] = '{CH_MINUS, CH_POINT, CH_POINT, CH_PLUS, CH_SPACE};
    logic [2:0] sc [4] = '{3'b010, 3'b001, 3'b110, 3'b101};
    logic [2:0] se [4] = '{3'b100, 3'b010, 3'b101, 3'b011};
    edit_float = 1'b0;
    edit_text = 1'b1;
    text_keys(4'h2, "2ABCabc2");
    text_keys(4'h9, "9WXYZwxyz9");
    text_keys(4'h1, "1 _");
    key(4'hc, 1'b0, 1'b0);
    check("digit above nine", 16'h0, {15'h0, char_valid});
    edit_text = 1'b0;
    edit_float = 1'b1;
    for (i = 0; i < 5; i++) begin
      {cursor_at_start, neg_allowed, key_plus} = fc[i];
      key(4'h0, fc[i][0], !fc[i][0]);
      check("float char", {8'h01, fe[i]}, {7'h0, char_valid, edit_char});
    end
    edit_float = 1'b0;
    for (i = 0; i < 4; i++) begin
      edit_month = sc[i][2];
      key(4'h0, sc[i][1], sc[i][0]);
      check("step", 16'(se[i]), {13'h0, step_up, step_down, month_step});
    end
  endtask : edit_keys
  task automatic hold(input logic up, input logic dn, input logic home, input int lo, input int hi);
    int d;
    logic [7:0] c0;
    home_screen = home;
    c0 = contrast;
    {key_up_held, key_down_held} = {up, dn};
    repeat (40) @(posedge clk);
    #1 {key_up_held, key_down_held} = 2'b00;
    repeat (6) @(posedge clk);
    #1 d = int'(contrast) - int'(c0);
    check("contrast change", 16'h1, {15'h0, d >= lo && d <= hi});
  endtask : hold
  initial begin
    repeat (2) @(posedge clk);
    warm_up();
    run_cycle(1'b0, 1'b0);
    run_cycle(1'b1, 1'b0);
    check("setpoint", 16'(TEMP_TARGET), 16'(heat_setpoint));
    run_cycle(1'b0, 1'b1);
    lights();
    green_button();
    edit_keys();
    hold(1'b1, 1'b0, 1'b1, 7, 11);
    hold(1'b0, 1'b1, 1'b1, -11, -7);
    hold(1'b1, 1'b0, 1'b0, 0, 0);
    end_of_test();
  end
endmodule : analyser_seq_test
